// ===== tcs_consts.vh
// Constants for the trip circuit supervisor: register map, fields, reset values and timing
//
// Notes on behaviour
// - Enable setting switches supervision; active flag follows the enable setting.
// - Selected blocking event inhibits pickup and trip and raises blocked flag; clears automatically.
// - Blocking selector zero selects no source, so supervision is never blocked.
// - Mode both watches 0/0 and 1/1, closed 1/1 only, open 0/0 only.
// - Pickup needs enable, a watched equal pattern and no blocking.
// - Pickup asserts as soon as the pattern is seen; delay timing starts.
// - Pickup held for the full delay raises the trip flag.
// - Pattern gone clears pickup and trip automatically, no acknowledge needed.
// - Trip delay 0 to 6553.5 s in 0.1 s steps, default 5 s.
// - One breaker per instance; four selectable sets of one settings group each.
`ifndef TCS_CONSTS_VH
`define TCS_CONSTS_VH

// Clock and timebase
`define TCS_CLK_HZ          25000000
`define TCS_TICK_MS         100

// Field widths
`define TCS_SEL_W           14
`define TCS_DELAY_W         16
`define TCS_SET_COUNT       4

// Global register byte addresses
`define TCS_ADDR_SET_SEL    8'h40
`define TCS_ADDR_STATUS     8'h44
`define TCS_ADDR_INT_STAT   8'h48
`define TCS_ADDR_INT_MASK   8'h4c

// Per-set registers, set k at k * 16
`define TCS_SET_REGION      2'h0
`define TCS_SREG_CTRL       2'h0
`define TCS_SREG_BLOCK      2'h1
`define TCS_SREG_FEEDBACK   2'h2
`define TCS_SREG_DELAY      2'h3

// Field positions
`define TCS_CTRL_EN_BIT     0
`define TCS_FB_OPEN_LSB     16

// Supervision modes
`define TCS_MODE_BOTH       2'h0
`define TCS_MODE_CLOSED     2'h1
`define TCS_MODE_OPEN       2'h2

// Reset values
`define TCS_RST_MODE        2'h0
`define TCS_RST_CLOSED_SEL  14'h177a
`define TCS_RST_OPEN_SEL    14'h177b
`define TCS_RST_DELAY       16'h0032
`define TCS_RST_BLOCK_SEL   14'h0000

// Interrupt status bits
`define TCS_IRQ_PICKUP      0
`define TCS_IRQ_TRIP        1
`define TCS_IRQ_BLOCKED     2
`define TCS_IRQ_W           3

`endif

// ===== tcs_top.v
// Trip circuit supervisor with AHB-Lite register slave and interrupt
//
// Register access over AHB-Lite and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "tcs_consts.vh"

module tcs_top #(
    parameter EVENT_COUNT = 16,
    parameter TICK_CYCLES = `TCS_CLK_HZ / 1000 * `TCS_TICK_MS
) (
    input  wire                   clk_sys,
    input  wire                   resetn,
    // AHB-Lite slave
    input  wire                   hsel,
    input  wire [31:0]            haddr,
    input  wire [1:0]             htrans,
    input  wire                   hwrite,
    input  wire [2:0]             hsize,
    input  wire [31:0]            hwdata,
    input  wire                   hready,
    output reg  [31:0]            hrdata,
    output reg                    hreadyout,
    output reg                    hresp,
    // Breaker feedback and event sources
    input  wire                   aux_closed_in,
    input  wire                   aux_open_in,
    input  wire [EVENT_COUNT-1:0] event_in,
    // Indications
    output reg                    supervision_active_flag,
    output reg                    supervision_blocked_flag,
    output reg                    supervision_pickup_flag,
    output reg                    supervision_trip_flag,
    output reg                    irq
);

    localparam SW = `TCS_SEL_W;
    localparam DW = `TCS_DELAY_W;
    localparam NS = `TCS_SET_COUNT;
    localparam IW = `TCS_IRQ_W;

    // Per-set settings, flattened per field
    reg  [NS-1:0]      set_enable;
    reg  [2*NS-1:0]    set_mode;
    reg  [SW*NS-1:0]   set_block_sel;
    reg  [SW*NS-1:0]   set_closed_sel;
    reg  [SW*NS-1:0]   set_open_sel;
    reg  [DW*NS-1:0]   set_delay;

    // Global control and interrupt state
    reg  [1:0]         active_set;
    reg  [IW-1:0]      int_status;
    reg  [IW-1:0]      int_mask;

    // Bus data-phase state
    reg                wr_pending;
    reg  [7:0]         wr_addr;

    // Read stall state
    reg                rd_stall;
    reg  [7:0]         rd_addr;

    // Supervision state
    reg                closed_meta;
    reg                closed_sync;
    reg                open_meta;
    reg                open_sync;
    reg  [31:0]        tick_div;
    reg  [DW-1:0]      tenths;

    // Selected set, live
    wire               function_enable_setting = set_enable[active_set];
    wire [1:0]         supervision_mode_select = set_mode[active_set*2 +: 2];
    wire [SW-1:0]      blocking_event_select   = set_block_sel[active_set*SW +: SW];
    wire [SW-1:0]      closed_feedback_select  = set_closed_sel[active_set*SW +: SW];
    wire [SW-1:0]      open_feedback_select    = set_open_sel[active_set*SW +: SW];
    wire [DW-1:0]      trip_delay_setting      = set_delay[active_set*DW +: DW];

    // Bus address phase decode
    wire               bus_take  = hsel & htrans[1] & hready;
    wire               bus_read  = bus_take & ~hwrite;
    wire               bus_write = bus_take & hwrite;

    // Blocking source lookup; zero and out-of-range select nothing
    reg                block_hit;
    integer            k;
    always @*
    begin
        block_hit = 1'b0;
        for (k = 0; k < EVENT_COUNT; k = k + 1)
        begin
            if (blocking_event_select == k[SW-1:0] + 1'b1)
                block_hit = event_in[k];
        end
    end

    // Watched pattern on synchronised feedback
    reg                pattern_hit;
    always @*
    begin
        case (supervision_mode_select)
            `TCS_MODE_BOTH:   pattern_hit = ~(closed_sync ^ open_sync);
            `TCS_MODE_CLOSED: pattern_hit = closed_sync & open_sync;
            `TCS_MODE_OPEN:   pattern_hit = ~closed_sync & ~open_sync;
            default:          pattern_hit = 1'b0;
        endcase
    end

    // Pickup and trip conditions
    wire               blocked_now = function_enable_setting & block_hit;
    wire               fault_now   = function_enable_setting & ~block_hit
                                     & pattern_hit;
    wire               tick        = (tick_div == TICK_CYCLES - 1);
    wire               delay_done  = (tenths >= trip_delay_setting);
    wire               next_trip   = fault_now & supervision_pickup_flag
                                     & delay_done;

    // Interrupt events, one-cycle rises of the indications
    wire [IW-1:0]      irq_events;
    assign irq_events[`TCS_IRQ_PICKUP]  = fault_now & ~supervision_pickup_flag;
    assign irq_events[`TCS_IRQ_TRIP]    = next_trip & ~supervision_trip_flag;
    assign irq_events[`TCS_IRQ_BLOCKED] = blocked_now & ~supervision_blocked_flag;

    // Write-one-to-clear mask from the data phase
    wire               wr_int_stat = wr_pending & (wr_addr == `TCS_ADDR_INT_STAT);
    wire [IW-1:0]      w1c_mask    = wr_int_stat ? hwdata[IW-1:0] : {IW{1'b0}};
    wire [IW-1:0]      next_int_status = (int_status & ~w1c_mask) | irq_events;

    // Data-phase set register decode
    wire               wr_set_region = wr_pending & (wr_addr[7:6] == `TCS_SET_REGION);
    wire [1:0]         wr_set        = wr_addr[5:4];
    wire [1:0]         wr_sreg       = wr_addr[3:2];

    // Set register writes, one slice per set
    genvar g;
    generate
        for (g = 0; g < NS; g = g + 1)
        begin : gen_set
            wire sel = wr_set_region & (wr_set == g);
            always @(posedge clk_sys or negedge resetn)
            begin
                if (!resetn)
                begin
                    set_enable[g]                 <= 1'b0;
                    set_mode[g*2 +: 2]            <= `TCS_RST_MODE;
                    set_block_sel[g*SW +: SW]     <= `TCS_RST_BLOCK_SEL;
                    set_closed_sel[g*SW +: SW]    <= `TCS_RST_CLOSED_SEL;
                    set_open_sel[g*SW +: SW]      <= `TCS_RST_OPEN_SEL;
                    set_delay[g*DW +: DW]         <= `TCS_RST_DELAY;
                end
                else if (sel)
                begin
                    case (wr_sreg)
                        `TCS_SREG_CTRL:
                        begin
                            set_enable[g]      <= hwdata[`TCS_CTRL_EN_BIT];
                            set_mode[g*2 +: 2] <= hwdata[`TCS_CTRL_EN_BIT+2:`TCS_CTRL_EN_BIT+1];
                        end
                        `TCS_SREG_BLOCK:
                            set_block_sel[g*SW +: SW] <= hwdata[SW-1:0];
                        `TCS_SREG_FEEDBACK:
                        begin
                            set_closed_sel[g*SW +: SW] <= hwdata[SW-1:0];
                            set_open_sel[g*SW +: SW]   <= hwdata[`TCS_FB_OPEN_LSB+SW-1:`TCS_FB_OPEN_LSB];
                        end
                        `TCS_SREG_DELAY:
                            set_delay[g*DW +: DW] <= hwdata[DW-1:0];
                        default:
                            set_enable[g] <= set_enable[g];
                    endcase
                end
            end
        end
    endgenerate

    // Global registers and bus data-phase tracking
    always @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            wr_pending <= 1'b0;
            wr_addr    <= 8'h00;
            active_set <= 2'h0;
            int_mask   <= {IW{1'b0}};
            int_status <= {IW{1'b0}};
        end
        else
        begin
            wr_pending <= bus_write;
            if (bus_take)
                wr_addr <= haddr[7:0];
            if (wr_pending && wr_addr == `TCS_ADDR_SET_SEL)
                active_set <= hwdata[1:0];
            if (wr_pending && wr_addr == `TCS_ADDR_INT_MASK)
                int_mask <= hwdata[IW-1:0];
            int_status <= next_int_status;                      // Set wins over clear
        end
    end

    // Read source: a stalled read decodes its own latched address
    wire [7:0] rd_src = rd_stall ? rd_addr : haddr[7:0];

    // Read data, captured in the address phase or again after a stall
    reg [31:0] next_rdata;
    always @*
    begin
        next_rdata = 32'h0000_0000;
        if (rd_src[7:6] == `TCS_SET_REGION)
        begin
            case (rd_src[3:2])
                `TCS_SREG_CTRL:
                    next_rdata = {29'h0000_0000, set_mode[rd_src[5:4]*2 +: 2],
                                  set_enable[rd_src[5:4]]};
                `TCS_SREG_BLOCK:
                    next_rdata = {18'h00000, set_block_sel[rd_src[5:4]*SW +: SW]};
                `TCS_SREG_FEEDBACK:
                    next_rdata = {2'h0, set_open_sel[rd_src[5:4]*SW +: SW],
                                  2'h0, set_closed_sel[rd_src[5:4]*SW +: SW]};
                `TCS_SREG_DELAY:
                    next_rdata = {16'h0000, set_delay[rd_src[5:4]*DW +: DW]};
                default:
                    next_rdata = 32'h0000_0000;
            endcase
        end
        else
        begin
            case (rd_src)
                `TCS_ADDR_SET_SEL:
                    next_rdata = {30'h0000_0000, active_set};
                `TCS_ADDR_STATUS:
                    next_rdata = {26'h0000000, open_sync, closed_sync,
                                  supervision_trip_flag, supervision_pickup_flag,
                                  supervision_blocked_flag, supervision_active_flag};
                `TCS_ADDR_INT_STAT:
                    next_rdata = {{(32-IW){1'b0}}, int_status};
                `TCS_ADDR_INT_MASK:
                    next_rdata = {{(32-IW){1'b0}}, int_mask};
                default:
                    next_rdata = 32'h0000_0000;
            endcase
        end
    end

    // Bus outputs: one wait state only for a read behind a landing write, always OKAY
    always @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
        else
        begin
            hreadyout <= ~(bus_read & wr_pending);
            hresp     <= 1'b0;
            if (bus_read || rd_stall)
                hrdata <= next_rdata;
        end
    end

    // Read stall: a read that meets a landing write is decoded again one cycle later
    always @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            rd_stall <= 1'b0;
            rd_addr  <= 8'h00;
        end
        else
        begin
            rd_stall <= bus_read & wr_pending;       // Write lands at this edge
            if (bus_read)
                rd_addr <= haddr[7:0];
        end
    end

    // Two-stage synchroniser on the breaker feedback
    always @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            closed_meta <= 1'b0;
            closed_sync <= 1'b0;
            open_meta   <= 1'b0;
            open_sync   <= 1'b0;
        end
        else
        begin
            closed_meta <= aux_closed_in;
            closed_sync <= closed_meta;
            open_meta   <= aux_open_in;
            open_sync   <= open_meta;
        end
    end

    // Tenth-second timebase, runs only while picked up
    always @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            tick_div <= 32'h0000_0000;
            tenths   <= {DW{1'b0}};
        end
        else if (!(fault_now && supervision_pickup_flag))
        begin
            tick_div <= 32'h0000_0000;
            tenths   <= {DW{1'b0}};
        end
        else if (tick)
        begin
            tick_div <= 32'h0000_0000;
            if (tenths != {DW{1'b1}})
                tenths <= tenths + 1'b1;
        end
        else
        begin
            tick_div <= tick_div + 32'h0000_0001;
        end
    end

    // Indications and interrupt line
    always @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            supervision_active_flag  <= 1'b0;
            supervision_blocked_flag <= 1'b0;
            supervision_pickup_flag  <= 1'b0;
            supervision_trip_flag    <= 1'b0;
            irq                      <= 1'b0;
        end
        else
        begin
            supervision_active_flag  <= function_enable_setting;
            supervision_blocked_flag <= blocked_now;
            supervision_pickup_flag  <= fault_now;
            supervision_trip_flag    <= next_trip;
            irq                      <= |(next_int_status & int_mask);
        end
    end

endmodule // tcs_top

`default_nettype wire

// ===== tcs_breaker_model.sv
// Breaker model driving the two auxiliary contact feedback inputs
`timescale 1ns/1ps
`default_nettype none
module tcs_breaker_model (
    input  wire logic       clk_sys,
    input  wire logic       breaker_closed,
    input  wire logic [1:0] wire_fault,
    output logic            aux_closed_in,
    output logic            aux_open_in
);
    logic       pos    = 1'b1;
    logic [1:0] travel = 2'h0;
    // Main contact follows the command after a three cycle travel
    always @(posedge clk_sys)
    begin
        if (travel != 2'h0)
            travel <= travel - 2'h1;
        else if (pos != breaker_closed)
            travel <= 2'h3;
        if (travel == 2'h1)
            pos <= ~pos;
    end
    // Both contacts open in travel; fault 1 or 2 breaks a line, 3 bridges both high
    assign aux_closed_in = wire_fault == 2'h3 || wire_fault != 2'h1 && travel == 2'h0 && pos;
    assign aux_open_in   = wire_fault == 2'h3 || wire_fault != 2'h2 && travel == 2'h0 && !pos;
endmodule // tcs_breaker_model
`default_nettype wire

// ===== tcs_top_asserts.sv
// Port assertions for the trip circuit supervisor
`timescale 1ns/1ps
`default_nettype none
module tcs_top_asserts (
    input wire logic        clk_sys,
    input wire logic        resetn,
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        aux_closed_in,
    input wire logic        aux_open_in,
    input wire logic        supervision_active_flag,
    input wire logic        supervision_blocked_flag,
    input wire logic        supervision_pickup_flag,
    input wire logic        supervision_trip_flag
);
    // Short names for the indications
    wire act = supervision_active_flag;
    wire blk = supervision_blocked_flag;
    wire pk  = supervision_pickup_flag;
    wire trp = supervision_trip_flag;
    // One clock domain, reset disables every check
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);
    // Feedback pair unequal for five samples running
    sequence s_pattern_gone;
        (aux_closed_in != aux_open_in)[*5];
    endsequence
    // Pickup just rose
    sequence s_pickup_rise;
        $rose(pk);
    endsequence
    // Relations between flags, feedback inputs and read data
    property p_blocked_active; blk |-> act; endproperty
    a_blocked_active: assert property (p_blocked_active)
        else $error("blocked without active");
    property p_pickup_gate; pk |-> act && !blk; endproperty
    a_pickup_gate: assert property (p_pickup_gate)
        else $error("pickup while off or blocked");
    property p_pickup_cause; s_pickup_rise |-> $past(aux_closed_in, 3) == $past(aux_open_in, 3); endproperty
    a_pickup_cause: assert property (p_pickup_cause)
        else $error("pickup without equal pair");
    property p_pattern_gone; s_pattern_gone |-> !pk && !trp; endproperty
    a_pattern_gone: assert property (p_pattern_gone)
        else $error("flags stay after pattern loss");
    property p_trip_pickup; trp |-> pk; endproperty
    a_trip_pickup: assert property (p_trip_pickup)
        else $error("trip without pickup");
    property p_trip_rise; $rose(trp) |-> $past(pk); endproperty
    a_trip_rise: assert property (p_trip_rise)
        else $error("trip rose before pickup");
    property p_timer_restart; s_pickup_rise |-> !trp; endproperty
    a_timer_restart: assert property (p_timer_restart)
        else $error("trip standing at new pickup");
    property p_rdata_hold; hready && !(hsel && htrans[1] && !hwrite) |=> $stable(hrdata); endproperty
    a_rdata_hold: assert property (p_rdata_hold)
        else $error("read data changed without read");
endmodule // tcs_top_asserts
bind tcs_top tcs_top_asserts u_tcs_asserts (
    .clk_sys(clk_sys), .resetn(resetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hrdata(hrdata), .aux_closed_in(aux_closed_in), .aux_open_in(aux_open_in),
    .supervision_active_flag(supervision_active_flag),
    .supervision_blocked_flag(supervision_blocked_flag),
    .supervision_pickup_flag(supervision_pickup_flag),
    .supervision_trip_flag(supervision_trip_flag)
);
`default_nettype wire

// ===== tcs_top_tb.sv
// Self-checking bench for the trip circuit supervisor
`timescale 1ns/1ps
`default_nettype none
`include "tcs_consts.vh"
module tcs_top_tb;
    logic        clk_sys = 1'b0;
    logic        resetn = 1'b0;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [1:0]  wire_fault = 2'h0;
    logic        brk_closed = 1'b1;
    logic [15:0] event_in = 16'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] lfsr = 32'hc691c08c;
    logic [31:0] exp_q[$];
    logic [31:0] seen_q[$];
    wire  [31:0] hrdata;
    wire         hreadyout;
    wire         hresp;
    wire         aux_c;
    wire         aux_o;
    wire  [4:0]  flg;
    int          failures = 0;
    int          total_checks = 0;
    int          cycles = 0;
    // Design, short tick for quick delays
    tcs_top #(.EVENT_COUNT(16), .TICK_CYCLES(10)) dut (
        .clk_sys(clk_sys), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .aux_closed_in(aux_c), .aux_open_in(aux_o),
        .event_in(event_in), .supervision_active_flag(flg[0]), .supervision_blocked_flag(flg[1]),
        .supervision_pickup_flag(flg[2]), .supervision_trip_flag(flg[3]), .irq(flg[4])
    );
    tcs_breaker_model u_brk (.clk_sys(clk_sys), .breaker_closed(brk_closed),
        .wire_fault(wire_fault), .aux_closed_in(aux_c), .aux_open_in(aux_o));
    // Clock and cycle ceiling
    initial
    begin
        forever #20 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            failures++;
            end_of_test();
        end
    end
    // Monitor pairs each observation with the oldest note
    always @(negedge clk_sys)
        while (seen_q.size() > 0)
            check(seen_q.pop_front(), exp_q.pop_front());
    function automatic logic [31:0] next_lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks=%0d failures=%0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // One single word transfer, address then data phase
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        exp_q.push_back(exp);
        seen_q.push_back(hrdata);
        exp_q.push_back(32'h0);
        seen_q.push_back({31'h0, hresp});
    endtask
    // Flags as irq, trip, pickup, blocked, active
    task automatic flags(input logic [4:0] exp);
        exp_q.push_back({27'h0, exp});
        seen_q.push_back({27'h0, flg});
    endtask
    task automatic wait_pickup();
        for (int n = 0; n < 50 && flg[2] !== 1'b1; n++)
            @(posedge clk_sys);
    endtask
    // Main sequence
    initial
    begin
        tick(12);
        resetn <= 1'b1;
        tick(1);
        flags(5'h00);
        rdchk(8'h08, 32'h177b177a);
        rdchk(8'h0c, 32'h32);
        wr(8'h80, 32'hffffffff);
        rdchk(8'h80, 32'h0);
        $display("reset test done");
        wr(8'h0c, 32'hffff);
        rdchk(8'h0c, 32'hffff);
        for (int m = 0; m < 4; m++)
        begin
            wr(8'h00, {29'h0, m[1:0], 1'b1});
            for (int p = 0; p < 4; p++)
            begin
                lfsr = next_lfsr(lfsr);
                event_in <= lfsr[15:0];
                brk_closed <= p != 1;
                wire_fault <= p < 2 ? 2'h0 : (p == 2 ? 2'h1 : 2'h3);
                tick(12);
                flags({2'b00, (m < 2 && p == 3) || (m % 2 == 0 && p == 2), 2'b01});
            end
        end
        $display("mode test done");
        wr(8'h00, 32'h1);
        wr(8'h04, 32'h5);
        event_in <= 16'h0010;
        tick(6);
        flags(5'h03);
        event_in <= 16'hffef;
        tick(6);
        flags(5'h05);
        $display("blocking test done");
        for (int d = 0; d <= 3; d += 3)
        begin
            wire_fault <= 2'h0;
            wr(8'h0c, 32'(d));
            tick(6);
            wire_fault <= 2'h3;
            wait_pickup();
            tick(15);
            wire_fault <= 2'h0;
            tick(6);
            wire_fault <= 2'h3;
            wait_pickup();
            tick(d * 10);
            flags(5'h05);
            tick(1);
            flags(5'h0d);
        end
        wire_fault <= 2'h0;
        tick(5);
        flags(5'h01);
        $display("delay test done");
        rdchk(`TCS_ADDR_INT_STAT, 32'h7);
        wr(`TCS_ADDR_INT_STAT, 32'h5);
        wr(`TCS_ADDR_INT_MASK, 32'h1);
        tick(2);
        flags(5'h01);
        wire_fault <= 2'h3;
        tick(8);
        flags(5'h15);
        rdchk(`TCS_ADDR_STATUS, 32'h35);
        rdchk(`TCS_ADDR_INT_STAT, 32'h3);
        wr(`TCS_ADDR_INT_STAT, 32'h1);
        tick(2);
        flags(5'h05);
        $display("interrupt test done");
        wr(8'h00, 32'h0);
        tick(3);
        flags(5'h00);
        wr(`TCS_ADDR_SET_SEL, 32'h1);
        wr(8'h10, 32'h1);
        tick(5);
        flags(5'h15);
        rdchk(`TCS_ADDR_SET_SEL, 32'h1);
        $display("set test done");
        resetn <= 1'b0;
        tick(2);
        flags(5'h00);
        resetn <= 1'b1;
        tick(2);
        flags(5'h00);
        rdchk(`TCS_ADDR_SET_SEL, 32'h0);
        $display("mid-run reset test done");
        tick(2);
        end_of_test();
    end
endmodule // tcs_top_tb
`default_nettype wire
